// ---- logic/rcspi_pkg.sv ----
/*
  rcspi_pkg: constants shared by the residual-current serial readout.
  Assumes a 125 MHz system clock; all cycle counts derive from it.
*/
package rcspi_pkg;

  // clock and timing
  localparam int unsigned CLK_NS          = 8;
  localparam int unsigned STARTUP_MS      = 100;
  localparam int unsigned STARTUP_CYC_DEF =
    STARTUP_MS * 1000000 / CLK_NS;
  localparam int unsigned FAULT_REACT_US  = 200;
  localparam int unsigned FAULT_REACT_CYC =
    FAULT_REACT_US * 1000 / CLK_NS;
  // toggle rate picked mid-band; half period rounds down
  localparam int unsigned FAULT_TOGGLE_HZ = 16000;
  localparam int unsigned FAULT_HALF_CYC  =
    1000000000 / (2 * FAULT_TOGGLE_HZ * CLK_NS);
  localparam int unsigned FAULT_CNT_W     = 12;

  // frame layout
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned FRAME_BITS = 40;
  localparam int unsigned IDX_W      = 6;
  localparam logic [5:0]  IDX_FIRST  = 6'h27;
  localparam int unsigned FIFO_DEPTH = 8;

  // sample coding and crc
  localparam logic [15:0] MID_SCALE = 16'h8000;
  localparam logic [7:0]  CRC_INIT  = 8'hff;
  localparam logic [7:0]  CRC_POLY  = 8'h07;

  // error word fields
  localparam logic [9:0]  ERR_FILL    = 10'h3ff;
  localparam int unsigned ERR_FILL_LO = 6;
  localparam logic [1:0]  ERR_RSVD    = 2'h0;
  localparam int unsigned ERR_HW      = 3;
  localparam int unsigned ERR_ZERO    = 2;
  localparam int unsigned ERR_OOR     = 1;
  localparam int unsigned ERR_OVL     = 0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } rcspi_state_e;

endpackage

// ---- logic/rcspi_fifo.sv ----
/*
  rcspi_fifo: flip-flop FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-low reset; DEPTH a power of two.
*/
`timescale 1ns/100ps
module rcspi_fifo #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  wire          full  = (wr_q[AW] != rd_q[AW]) &&
                        (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire          empty = (wr_q == rd_q);
  wire          push  = in_valid && !full;
  wire          pop   = out_ready && !empty;
  // fill level from the pointers, independent of the full decode
  wire [AW:0]   fill  = wr_q - rd_q;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  property p_fill_bound;
    @(posedge clock) disable iff (!reset_n)
      fill <= DEPTH;
  endproperty
  a_fill_bound: assert property (p_fill_bound)
    else $error("fifo holds more entries than its depth");

  property p_full_refuse;
    @(posedge clock) disable iff (!reset_n)
      fill == DEPTH |-> !in_ready;
  endproperty
  a_full_refuse: assert property (p_full_refuse)
    else $error("fifo accepts data while full");

endmodule // rcspi_fifo

// ---- logic/rcspi_sdm.sv ----
/*
  rcspi_sdm: first-order sigma-delta modulator, complementary bit pair.
  Assumes an unsigned offset-binary input held on the same clock.
*/
`timescale 1ns/100ps
module rcspi_sdm #(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic              bit_pos,
  output logic              bit_neg
);
  logic [W-1:0] acc_q;
  wire  [W:0]   sum = {1'b0, acc_q} + {1'b0, din};

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      acc_q   <= '0;
      bit_pos <= 1'b0;
      bit_neg <= 1'b1;
    end else begin
      acc_q   <= sum[W-1:0];
      bit_pos <= sum[W];
      bit_neg <= !sum[W];
    end
  end

endmodule // rcspi_sdm

// ---- logic/rcspi_readout.sv ----
/*
  rcspi_readout: serial readout side of a residual-current sensor.
  Shifts five-byte frames on a mode 1 serial link, builds error words,
  drives the toggling fault pin and the sigma-delta bit pair.
  Assumes link pins arrive asynchronously and are oversampled by the
  125 MHz clock; samples come from same-clock filter logic.

  // Operation
  // RULE1: link uses mode 1, idle-low clock
  // RULE2: slave only, drives data line only
  // RULE3: host makes select and clock
  // RULE4: frame: fast word, slow word, crc
  // RULE5: crc-8, poly 0x07, start 0xff
  // RULE6: host checks crc over all five bytes
  // RULE7: crc byte makes frame crc zero
  // RULE8: any fault fills bits 15..6 ones
  // RULE9: error bits 5,4 reserved, ignored
  // RULE10: bit 3 flags self-check failure
  // RULE11: error bit 2 always zero
  // RULE12: bit 1 flags out-of-range current
  // RULE13: bit 0 flags critical overload
  // RULE14: self-check flag holds until power cycle
  // RULE15: out-of-range above threshold, sampling continues
  // RULE16: host ignores slow word on error
  // RULE17: fault indication within 200 us
  // RULE18: fault pin toggles 11-21 kHz when healthy
  // RULE19: up to 100 ms start-up
  // RULE20: host clock high/low 100 ns, period 250
  // RULE21: select high 200 ns between frames
  // RULE22: 100 ns last fall to select rise
  // RULE23: first word feeds sigma-delta modulator
  // RULE24: samples offset binary, zero at 32768
  // RULE25: fault freezes fault pin steady
  // RULE26: active-low reset restarts start-up
  // RULE27: msb first, change on rising edge
  // RULE28: coherent word pair latched at select
*/
`timescale 1ns/100ps
module rcspi_readout #(
  parameter int unsigned STARTUP_CYC = rcspi_pkg::STARTUP_CYC_DEF,
  parameter int unsigned FIFO_DEPTH  = rcspi_pkg::FIFO_DEPTH
) (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          por_n,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  output logic                               miso,
  output logic                               miso_oe,
  input  wire logic [rcspi_pkg::WORD_W-1:0]  hb_sample,
  input  wire logic [rcspi_pkg::WORD_W-1:0]  ha_sample,
  input  wire logic                          sample_valid,
  output logic                               sample_ready,
  input  wire logic                          over_range,
  input  wire logic                          overload,
  input  wire logic                          selftest_fail,
  output logic                               fault_pin,
  output logic                               analog_pos,
  output logic                               analog_neg,
  output logic                               ready
);
  import rcspi_pkg::*;

  function automatic logic [7:0] crc8_byte(input logic [7:0] c,
                                           input logic [7:0] b);
    logic [7:0] d;
    d = c ^ b;
    for (int i = 0; i < 8; i++) begin
      d = d[7] ? ({d[6:0], 1'b0} ^ CRC_POLY) : {d[6:0], 1'b0};
    end
    return d;
  endfunction

  // pin synchronisers; stage one feeds only stage two
  logic [2:0] sclk_sy_q;
  logic [2:0] cs_sy_q;
  logic [1:0] flt_s1_q;
  logic [1:0] flt_s2_q;
  logic [1:0] hw_s1_q;

  always_ff @(posedge clock) begin
    sclk_sy_q <= {sclk_sy_q[1:0], sclk};
    cs_sy_q   <= {cs_sy_q[1:0], cs_n};
    flt_s1_q  <= {over_range, overload};
    flt_s2_q  <= flt_s1_q;
    hw_s1_q   <= {hw_s1_q[0], selftest_fail};
  end

  // edges are found on stages two and three; host widths keep this safe
  wire sclk_rise = sclk_sy_q[1] && !sclk_sy_q[2]; // [RULE1] [RULE20]
  wire cs_sel    = !cs_sy_q[1];
  wire cs_fall   = !cs_sy_q[1] && cs_sy_q[2];
  wire oor_now   = flt_s2_q[1]; // [RULE15]
  wire ovl_now   = flt_s2_q[0];

  // self-check flag survives functional reset, only power-on clears
  logic hw_fault_q;
  always_ff @(posedge clock) begin
    if (!por_n) begin
      hw_fault_q <= 1'b0;
    end else if (hw_s1_q[1]) begin
      hw_fault_q <= 1'b1; // [RULE14]
    end
  end

  wire fault_any = hw_fault_q || oor_now || ovl_now;

  // start-up interval, restarted by every functional reset
  logic [$clog2(STARTUP_CYC+1)-1:0] start_cnt_q;
  logic                             ready_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      start_cnt_q <= '0; // [RULE26]
      ready_q     <= 1'b0;
    end else if (!ready_q) begin
      if (start_cnt_q == STARTUP_CYC[$bits(start_cnt_q)-1:0] - 1'b1)
      begin
        ready_q <= 1'b1; // [RULE19]
      end
      start_cnt_q <= start_cnt_q + 1'b1;
    end
  end
  assign ready = ready_q;

  // sample path through the fifo
  rcspi_state_e            state_q;
  rcspi_state_e            state_d;
  logic [2*WORD_W-1:0]     fifo_data;
  logic                    fifo_valid;
  logic [WORD_W-1:0]       hb_q;
  logic [WORD_W-1:0]       ha_q;
  // pairs stall in the fifo while a frame is on the wire
  wire                     fifo_pop = (state_q == ST_IDLE) && !cs_fall;

  rcspi_fifo #(
    .W     (2*WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_data   ({hb_sample, ha_sample}),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      hb_q <= MID_SCALE; // [RULE24]
      ha_q <= MID_SCALE;
    end else if (fifo_pop && fifo_valid) begin
      hb_q <= fifo_data[2*WORD_W-1:WORD_W];
      ha_q <= fifo_data[WORD_W-1:0];
    end
  end

  // first word: sample, or error code when any fault stands
  wire [WORD_W-1:0] err_word = {ERR_FILL, ERR_RSVD, hw_fault_q,
                                1'b0, oor_now, ovl_now};
  // [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13]
  wire [WORD_W-1:0] word1    = fault_any ? err_word : hb_q;
  wire [7:0]        crc_part = crc8_byte(crc8_byte(crc8_byte(
                                 crc8_byte(CRC_INIT, word1[15:8]),
                                 word1[7:0]), ha_q[15:8]), ha_q[7:0]);
  // running the crc over its own result leaves zero
  wire [FRAME_BITS-1:0] frame_d = {word1, ha_q, crc_part};
  // [RULE4] [RULE5] [RULE7]

  rcspi_sdm #(
    .W (WORD_W)
  ) u_sdm (
    .clock   (clock),
    .reset_n (reset_n),
    .din     (word1), // [RULE23]
    .bit_pos (analog_pos),
    .bit_neg (analog_neg)
  );

  // frame shifter
  logic [FRAME_BITS-1:0] frame_q;
  logic [IDX_W-1:0]      idx_q;
  logic                  miso_q;
  wire                   frame_go = cs_fall && ready_q;
  wire                   last_bit = (idx_q == '0);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (frame_go) state_d = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (!cs_sel) state_d = ST_IDLE;
        else if (sclk_rise && last_bit) state_d = ST_DONE;
      end
      ST_DONE: begin
        if (!cs_sel) state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      frame_q <= '0;
      idx_q   <= '0;
      miso_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && frame_go) begin
        frame_q <= frame_d; // [RULE28]
        idx_q   <= IDX_FIRST;
        miso_q  <= 1'b0;
      end else if (state_q == ST_SHIFT && sclk_rise) begin
        miso_q <= frame_q[idx_q]; // [RULE27]
        if (!last_bit) idx_q <= idx_q - 1'b1;
      end
    end
  end

  // released outside frames so a shared line stays free
  assign miso    = miso_q;
  assign miso_oe = cs_sel && (state_q != ST_IDLE); // [RULE2]

  // fault pin: free-running toggle, frozen while any fault stands
  logic [FAULT_CNT_W-1:0] tog_cnt_q;
  logic                   fault_pin_q;
  wire                    tog_wrap =
    (tog_cnt_q == FAULT_HALF_CYC[FAULT_CNT_W-1:0] - 1'b1);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tog_cnt_q   <= '0;
      fault_pin_q <= 1'b0;
    end else if (fault_any || !ready_q) begin
      tog_cnt_q <= '0; // [RULE25] [RULE17]
    end else if (tog_wrap) begin
      tog_cnt_q   <= '0;
      fault_pin_q <= !fault_pin_q; // [RULE18]
    end else begin
      tog_cnt_q <= tog_cnt_q + 1'b1;
    end
  end
  assign fault_pin = fault_pin_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  function automatic logic [7:0] crc_frame(input logic [39:0] f);
    logic [7:0] c;
    c = CRC_INIT;
    for (int k = 4; k >= 0; k--) begin
      c = crc8_byte(c, f[8*k +: 8]);
    end
    return c;
  endfunction

  sequence s_latch;
    state_q == ST_IDLE && frame_go;
  endsequence

  sequence s_latch_fault;
    state_q == ST_IDLE && frame_go && fault_any;
  endsequence

  property p_crc_zero;
    s_latch |=> crc_frame(frame_q) == 8'h00;
  endproperty
  a_crc_zero: assert property (p_crc_zero) // [RULE5] [RULE7]
    else $error("frame crc does not end at zero");

  property p_err_fill;
    s_latch_fault |=> frame_q[39:30] == ERR_FILL && !frame_q[26];
  endproperty
  a_err_fill: assert property (p_err_fill) // [RULE8] [RULE11]
    else $error("error word fill or zero bit wrong");

  property p_err_flags;
    s_latch_fault |=> frame_q[27] == $past(hw_fault_q) &&
      frame_q[25] == $past(oor_now) && frame_q[24] == $past(ovl_now);
  endproperty
  a_err_flags: assert property (p_err_flags) // [RULE10] [RULE12] [RULE13]
    else $error("error flag bits do not match causes");

  property p_hw_sticky;
    @(posedge clock) disable iff (!por_n) hw_fault_q |=> hw_fault_q;
  endproperty
  a_hw_sticky: assert property (p_hw_sticky) // [RULE14]
    else $error("self-check flag cleared without power-on");

  property p_first_bit;
    state_q == ST_SHIFT && sclk_rise && idx_q == IDX_FIRST
      |=> miso == frame_q[39] ##1 idx_q == 6'h26;
  endproperty
  a_first_bit: assert property (p_first_bit) // [RULE27] [RULE4]
    else $error("first bit out is not the frame msb");

  property p_frame_hold;
    state_q != ST_IDLE ##1 state_q != ST_IDLE |-> $stable(frame_q);
  endproperty
  a_frame_hold: assert property (p_frame_hold) // [RULE28]
    else $error("frame content changed mid-frame");

  property p_oe_selected;
    miso_oe |-> !cs_sy_q[1] && ready_q;
  endproperty
  a_oe_selected: assert property (p_oe_selected) // [RULE2] [RULE19]
    else $error("data line driven while not selected or not ready");

  property p_fault_freeze;
    fault_any [*2] |-> $stable(fault_pin);
  endproperty
  a_fault_freeze: assert property (p_fault_freeze) // [RULE25] [RULE17]
    else $error("fault pin moved while a fault stands");

  property p_toggle;
    ready_q && !fault_any && tog_wrap |=> fault_pin != $past(fault_pin);
  endproperty
  a_toggle: assert property (p_toggle) // [RULE18]
    else $error("fault pin missed its toggle");

endmodule // rcspi_readout

// ---- bench/rcspi_host.sv ----
/*
  rcspi_host: behavioural serial master reading five-byte frames.
  Assumes it is started on a system clock edge; the link clock
  edges then fall 2 ns after system edges.
*/
`timescale 1ns/100ps
module rcspi_host (
  output logic       sclk,
  output logic       cs_n,
  input  wire logic  miso,
  input  wire logic  miso_oe
);
  logic       miso_w;
  int         oe_cnt;
  logic [7:0] residue;

  // a released line shows the inverse of its last bit
  assign miso_w = miso_oe ? miso : ~miso;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] d;
    d = c ^ b;
    for (int i = 0; i < 8; i++) begin
      d = d[7] ? {d[6:0], 1'b0} ^ 8'h07 : {d[6:0], 1'b0};
    end
    return d;
  endfunction

  // select moves just off the system edge so its sampling is not a race
  task automatic hold(input logic v);
    #1 cs_n = v;
  endtask

  // half sets the link rate: 32 is fast, 128 keeps the 250 ns minimum
  task automatic read_frame(input int half, output logic [39:0] f);
    oe_cnt = 0;
    residue = 8'hff;
    #1 cs_n = 1'b0;
    #121;
    for (int i = 39; i >= 0; i--) begin
      sclk = 1'b1;
      #(half);
      sclk = 1'b0;
      f[i] = miso_w;
      if (miso_oe === 1'b1) oe_cnt++;
      #(half);
    end
    #100 cs_n = 1'b1;
    for (int k = 4; k >= 0; k--) begin
      residue = crc8(residue, f[8*k +: 8]);
    end
    // returns 1 ns past a system edge, never on one
    #203;
  endtask
endmodule // rcspi_host

// ---- bench/testbench.sv ----
/*
  testbench: self-checking bench for rcspi_readout.
  Assumes rcspi_host as link master; start-up shortened to 50 cycles.
*/
`timescale 1ns/100ps
module testbench;
  import rcspi_pkg::*;
  localparam int unsigned SU = 50;

  logic              clock;
  logic              reset_n;
  logic              por_n;
  logic              sample_valid;
  logic              over_range;
  logic              overload;
  logic              selftest_fail;
  logic [WORD_W-1:0] hb_sample;
  logic [WORD_W-1:0] ha_sample;
  logic [39:0]       fr;
  wire               sclk, cs_n, miso, miso_oe, sample_ready;
  wire               fault_pin, analog_pos, analog_neg, ready;
  int                mismatches;
  int                checks;

  rcspi_readout #(.STARTUP_CYC(SU), .FIFO_DEPTH(8)) dut (
    .clock(clock), .reset_n(reset_n), .por_n(por_n), .sclk(sclk),
    .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe),
    .hb_sample(hb_sample), .ha_sample(ha_sample),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .over_range(over_range), .overload(overload),
    .selftest_fail(selftest_fail), .fault_pin(fault_pin),
    .analog_pos(analog_pos), .analog_neg(analog_neg), .ready(ready));

  rcspi_host host (.sclk(sclk), .cs_n(cs_n), .miso(miso),
                   .miso_oe(miso_oe));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [39:0] exp_frame(input logic [15:0] a,
                                            input logic [15:0] b);
    logic [7:0] c;
    c = host.crc8(host.crc8(host.crc8(host.crc8(CRC_INIT, a[15:8]),
        a[7:0]), b[15:8]), b[7:0]);
    return {a, b, c};
  endfunction

  task automatic push(input logic [15:0] hb, input logic [15:0] ha);
    int n;
    @(posedge clock);
    hb_sample <= hb;
    ha_sample <= ha;
    sample_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sample_ready !== 1'b1 && n < 50);
    sample_valid <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    repeat (4) @(posedge clock);
  endtask

  // a frame started during start-up must see no drive
  task automatic do_reset;
    int n;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (12) @(posedge clock);
    check({miso_oe, ready, analog_neg}, 3'h1, "reset outputs");
    reset_n <= 1'b1;
    n = 0;
    fork
      host.read_frame(32, fr);
      while (ready !== 1'b1 && n < 500) begin
        @(posedge clock);
        n++;
      end
    join
    check(40'(n >= SU - 1 && n <= SU + 2), 40'd1, "start-up");
    check(40'(host.oe_cnt), 40'd0, "early frame driven");
    if (ready !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic t_frame;
    push(16'h8320, 16'he396);
    host.read_frame(32, fr);
    check(fr, 40'h8320e3960e, "frame");
    check(host.residue, 8'h00, "frame crc");
    check(40'(host.oe_cnt), 40'd40, "drive count");
    check(40'(analog_neg), 40'(!analog_pos), "analog pair");
    push(16'h8000, 16'h7fff);
    host.read_frame(128, fr);
    check(fr, exp_frame(16'h8000, 16'h7fff), "slow frame");
  endtask

  // word 2 is not judged while word 1 carries an error
  task automatic t_faults;
    for (int k = 1; k < 4; k++) begin
      @(posedge clock);
      over_range <= k[1];
      overload <= k[0];
      repeat (5) @(posedge clock);
      host.read_frame(32, fr);
      check(fr[39:24] & 16'hffcf, {10'h3ff, 4'h0, k[1:0]}, "err word");
      check(host.residue, 8'h00, "err crc");
    end
    @(posedge clock);
    over_range <= 1'b0;
    overload <= 1'b0;
    repeat (5) @(posedge clock);
  endtask

  task automatic until_toggle(output int n);
    logic lvl;
    lvl = fault_pin;
    n = 0;
    while (fault_pin === lvl && n < 6000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 6000) begin
      mismatches++;
      stop_test();
    end
  endtask

  task automatic t_fault_pin;
    int   n;
    int   moved;
    logic lvl;
    until_toggle(n);
    until_toggle(n);
    check(40'(n >= 2976 && n <= 5681), 40'd1, "toggle rate");
    overload <= 1'b1;
    repeat (5) @(posedge clock);
    // fixed watch window, longer than any healthy half period
    moved = 0;
    lvl = fault_pin;
    repeat (6000) begin
      @(posedge clock);
      if (fault_pin !== lvl) moved++;
    end
    check(40'(moved), 40'd0, "fault pin frozen");
    overload <= 1'b0;
    repeat (5) @(posedge clock);
  endtask

  // entries queue while selected, then drain into the held pair
  task automatic t_fifo;
    logic [8:0] seen;
    host.hold(1'b0);
    repeat (6) @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      hb_sample <= 16'h1000 + 16'(i);
      ha_sample <= 16'h2000 + 16'(i);
      sample_valid <= 1'b1;
      @(posedge clock);
      seen[8 - i] = sample_ready;
    end
    sample_valid <= 1'b0;
    check(seen, 9'h1fe, "fifo full");
    host.hold(1'b1);
    repeat (30) @(posedge clock);
    host.read_frame(32, fr);
    check(fr, exp_frame(16'h1007, 16'h2007), "drained pair");
  endtask

  task automatic t_sticky;
    @(posedge clock);
    selftest_fail <= 1'b1;
    @(posedge clock);
    selftest_fail <= 1'b0;
    repeat (5) @(posedge clock);
    for (int r = 0; r < 2; r++) begin
      host.read_frame(32, fr);
      check(fr[39:24] & 16'hffcf, 16'hffc8, "self-check");
      do_reset();
    end
    @(posedge clock);
    por_n <= 1'b0;
    @(posedge clock);
    por_n <= 1'b1;
    repeat (5) @(posedge clock);
    host.read_frame(32, fr);
    check(fr, exp_frame(MID_SCALE, MID_SCALE), "after power cycle");
  endtask

  initial begin
    mismatches = 0;
    checks = 0;
    reset_n = 1'b0;
    por_n = 1'b0;
    sample_valid = 1'b0;
    over_range = 1'b0;
    overload = 1'b0;
    selftest_fail = 1'b0;
    hb_sample = MID_SCALE;
    ha_sample = MID_SCALE;
    @(posedge clock);
    por_n <= 1'b1;
    do_reset();
    t_frame();
    t_faults();
    t_fault_pin();
    t_fifo();
    t_sticky();
    stop_test();
  end
endmodule // testbench
